// ### dv/pfm_pad_mux_assertions.sv
`default_nettype none
// port-level checks beside the pad function multiplexer
module pfm_pad_mux_assertions
  import pfm_pkg::*;
#(
  parameter int                NPAD      = 8,
  parameter logic [NPAD*3-1:0] POR_STATE = '0,
  parameter logic [NPAD*3-1:0] REL_STATE = '0
) (
  // clock and resets
  input wire logic            aclk,
  input wire logic            aresetn,
  input wire logic            por_n,
  input wire logic            warm_reset_output_signal_n,
  // register bus handshakes
  input wire logic            s_axi_awready,
  input wire logic            s_axi_wvalid,
  input wire logic            s_axi_wready,
  input wire logic [1:0]      s_axi_bresp,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_bready,
  input wire logic            s_axi_arvalid,
  input wire logic            s_axi_arready,
  input wire logic [31:0]     s_axi_rdata,
  input wire logic [1:0]      s_axi_rresp,
  input wire logic            s_axi_rvalid,
  input wire logic            s_axi_rready,
  // pad side
  input wire logic [NPAD-1:0] pad_o,
  input wire logic [NPAD-1:0] pad_oe,
  input wire logic [NPAD-1:0] pad_pu_en,
  input wire logic [NPAD-1:0] pad_pd_en
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // pad pins expected from the two state tables
  logic [NPAD-1:0] por_oe, por_o, por_pu, por_pd;
  logic [NPAD-1:0] rel_m, rel_oe, rel_pu, rel_pd;
  always_comb begin
    for (int p = 0; p < NPAD; p++) begin
      por_oe[p] = POR_STATE[p*3+:3] <= 3'h1;
      por_o[p]  = POR_STATE[p*3+:3] == 3'h1;
      por_pu[p] = POR_STATE[p*3+:3] == 3'h4;
      por_pd[p] = POR_STATE[p*3+:3] == 3'h3;
      // codes 0 and 1 follow the function, so they are masked out
      rel_m[p]  = REL_STATE[p*3+:3] >= 3'h2;
      rel_oe[p] = REL_STATE[p*3+:3] >= 3'h5;
      rel_pu[p] = REL_STATE[p*3+:3] == 3'h4;
      rel_pd[p] = REL_STATE[p*3+:3] == 3'h3;
    end
  end
  por_drive_a: assert property (
    !por_n && !$past(por_n, 2) |->
    ((pad_oe ^ por_oe) | ((pad_o ^ por_o) & por_oe)) == '0
  ) else $error("pad drive differs from power-on state");
  por_pull_a: assert property (
    !por_n && !$past(por_n, 2) |->
    pad_pu_en == por_pu && pad_pd_en == por_pd
  ) else $error("pad pulls differ from power-on state");
  rel_state_a: assert property (
    $rose(warm_reset_output_signal_n) && por_n |-> ##[1:3]
    (((pad_oe ^ rel_oe) | (pad_pu_en ^ rel_pu)
      | (pad_pd_en ^ rel_pd)) & rel_m) == '0
  ) else $error("pad state after warm release is wrong");
  aw_pulse_a: assert property (
    s_axi_awready |=> !s_axi_awready
  ) else $error("write address ready longer than one cycle");
  wr_answer_a: assert property (
    s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid
  ) else $error("write response late");
  rd_latency_a: assert property (
    s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid
  ) else $error("read data not two cycles after address");
  b_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)
  ) else $error("write response dropped before taken");
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
  ) else $error("read data dropped before taken");
  refused_zero_a: assert property (
    s_axi_rvalid && s_axi_rresp == PFM_RESP_SLVERR |-> s_axi_rdata == '0
  ) else $error("refused read returns data");
endmodule
bind pfm_pad_mux pfm_pad_mux_assertions #(.NPAD(NPAD),
  .POR_STATE(POR_STATE), .REL_STATE(REL_STATE)) u_chk (.aclk, .aresetn,
  .por_n, .warm_reset_output_signal_n, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .pad_o, .pad_oe, .pad_pu_en, .pad_pd_en);
`default_nettype wire

// ### dv/pfm_pad_mux_tb_top.sv
`default_nettype none
// self-checking bench for the pad function multiplexer
module pfm_pad_mux_tb_top
  import pfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NPAD = 8;
  localparam int NIN = 8;
  // state codes per pad, pad 0 in the lowest field
  localparam logic [23:0] POR_P = {3'h2,3'h2,3'h2,3'h4,3'h3,3'h2,3'h1,3'h0};
  localparam logic [23:0] REL_P = {3'h0,3'h0,3'h0,3'h0,3'h2,3'h4,3'h3,3'h5};
  localparam logic [31:0] DEF_P = 32'h7654_3210;
  localparam logic [7:0]  HAS_P = 8'h7f;
  localparam logic [15:0] DESEL_P = {2'h1,2'h0,2'h2,2'h1,2'h0,2'h2,2'h1,2'h0};
  // pad p feeds input p on even selects below 8, so no input has two pads
  function automatic logic [511:0] mk_map();
    logic [511:0] m;
    m = '1;
    for (int x = 0; x < NPAD*16; x++)
      if (x[3:0] < 4'h8 && !x[0]) m[x*4+:4] = 4'(x / 16);
    return m;
  endfunction
  localparam logic [511:0] MAP_P = mk_map();
  // stimulus, all driven from time zero
  logic         aclk = 1'b0, aresetn = 1'b0, por_n = 1'b0, pad_clk_src = 1'b0;
  logic         warm_reset_output_signal_n = 1'b0;
  logic [11:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]  s_axi_wdata = '0;
  logic [3:0]   s_axi_wstrb = 4'hf;
  logic         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [127:0] func_out = '0, func_oe = '0;
  logic [7:0]   pad_i = '0;
  // observed outputs
  logic         s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic         s_axi_arready, s_axi_rvalid;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic [31:0]  s_axi_rdata;
  logic [7:0]   periph_in, pad_o, pad_oe, pad_pu_en, pad_pd_en;
  // bench bookkeeping
  logic [31:0]  cfg [NPAD];
  logic [31:0]  seed = 32'ha2bb_d4ac;
  int           errors = 0;
  int           compares = 0;
  always #10 aclk = ~aclk;
  pfm_pad_mux #(.NPAD(NPAD), .NIN(NIN), .AW(3), .IW(3), .POR_STATE(POR_P),
    .DEF_SEL(DEF_P), .REL_STATE(REL_P), .HAS_PULL(HAS_P), .IN_MAP(MAP_P),
    .DESEL_VAL(DESEL_P)) uut (.aclk, .aresetn, .por_n,
    .warm_reset_output_signal_n,
    .pad_clk_src, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .func_out, .func_oe,
    .periph_in, .pad_i, .pad_o, .pad_oe, .pad_pu_en, .pad_pd_en);
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // expected {oe, o, pu, pd} of a pad parked in a state code
  function automatic logic [3:0] st(input logic [2:0] c);
    return {c <= 3'h1 || c >= 3'h5, c == 3'h1, c == 3'h4, c == 3'h3};
  endfunction
  function automatic logic [3:0] pin(input int p);
    return {pad_oe[p], pad_o[p], pad_pu_en[p], pad_pd_en[p]};
  endfunction
  // pads of configured pads, as {oe, o, pu, pd} vectors
  function automatic logic [31:0] exp_pads();
    logic [7:0] oe, o, pu, pd;
    int x;
    for (int p = 0; p < NPAD; p++) begin
      x = p * 16 + int'(cfg[p][3:0]);
      o[p] = func_out[x];
      oe[p] = func_oe[x] & ~cfg[p][18];
      pu[p] = cfg[p][16] & cfg[p][17] & HAS_P[p];
      pd[p] = cfg[p][16] & ~cfg[p][17] & HAS_P[p];
    end
    return {oe, o, pu, pd};
  endfunction
  // pin-state code reads 0 when nothing routes the input
  function automatic logic [7:0] exp_in();
    logic [7:0] v;
    for (int p = 0; p < NPAD; p++) begin
      v[p] = DESEL_P[p*2+:2] == PFM_DESEL_ONE;
      if (!cfg[p][3] && !cfg[p][0]) v[p] = pad_i[p];
    end
    return v;
  endfunction
  task automatic cmp(input string what, input logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask
  // one write: address and data together, response taken after a stall
  task automatic axw(input logic [11:0] a, input logic [31:0] v,
                     output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [11:0] a, output logic [31:0] v,
                     output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic close_out();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // watchdog, far beyond the roughly 800 cycles the run needs
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    close_out();
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int p;
    repeat (20) @(posedge aclk);
    for (p = 0; p < NPAD; p++) cmp("por pad", st(POR_P[p*3+:3]), pin(p));
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    for (p = 0; p < NPAD; p++) cmp("por pad", st(POR_P[p*3+:3]), pin(p));
    axw(12'h000, 32'h0000_0001, r);
    cmp("early bresp", PFM_RESP_SLVERR, r);
    por_n <= 1'b1;
    repeat (3) @(posedge aclk);
    axr(12'hffc, d, r);
    cmp("phase", 32'(PFM_PH_HOLD), d);
    warm_reset_output_signal_n <= 1'b1;
    repeat (4) @(posedge aclk);
    for (p = 1; p < 4; p++) cmp("rel pad", st(REL_P[p*3+:3]), pin(p));
    for (int k = 0; k < 2; k++) begin
      pad_clk_src <= (k == 0);
      repeat (3) @(posedge aclk);
      cmp("clock pad", {1'b1, k == 0, 2'b00}, pin(0));
    end
    axr(12'hffc, d, r);
    cmp("phase", 32'(PFM_PH_RUN), d);
    for (p = 0; p < NPAD; p++) begin
      axr(12'(4 * p), d, r);
      cmp("default sel", DEF_P[p*4+:4], d & 32'h0000_000f);
      cfg[p] = '0;
      axw(12'(4 * p), '0, r);
    end
    // first every select in turn, then random pads and fields
    for (int i = 0; i < 48; i++) begin
      d = xs() & 32'h0007_000f;
      if (i < 16) d = {13'h0, i[0], i[2], i[1], 12'h0, i[3:0]};
      p = (i < 16) ? i % 8 : int'(xs() % 8);
      axw(12'(4 * p), d, r);
      cmp("bresp", PFM_RESP_OKAY, r);
      cfg[p] = d;
      // a pad without resistors keeps its pull enable at zero
      cfg[p][16] = d[16] & HAS_P[p];
      func_out <= {xs(), xs(), xs(), xs()};
      func_oe <= {xs(), xs(), xs(), xs()};
      pad_i <= 8'(xs());
      repeat (3) @(posedge aclk);
      cmp("pads", exp_pads(),
          {pad_oe, pad_o, pad_pu_en, pad_pd_en});
      cmp("periph in", exp_in(), periph_in);
      axr(12'(4 * p), d, r);
      cmp("cfg readback", cfg[p], d & 32'h0007_000f);
    end
    axr(12'h800, d, r);
    cmp("pad status", {24'h0, pad_i}, d);
    axr(12'h400, d, r);
    cmp("unmapped rresp", PFM_RESP_SLVERR, r);
    cmp("unmapped rdata", '0, d);
    axw(12'h002, 32'h0000_0001, r);
    cmp("misaligned bresp", PFM_RESP_SLVERR, r);
    // power-on reset again in mid-run, then a bus reset on top of it
    por_n <= 1'b0;
    repeat (3) @(posedge aclk);
    for (p = 0; p < NPAD; p++) cmp("por again", st(POR_P[p*3+:3]), pin(p));
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (p = 0; p < NPAD; p++) cmp("por rst", st(POR_P[p*3+:3]), pin(p));
    axr(12'hffc, d, r);
    cmp("phase", 32'(PFM_PH_POR), d);
    close_out();
  end
endmodule
`default_nettype wire

// ### hdl/pfm_cfg_mem.sv
`default_nettype none
// pad configuration storage, registered read port
module pfm_cfg_mem
  import pfm_pkg::*;
#(
  parameter int NPAD = 8,
  parameter int AW   = 3
) (
  // clock
  input  wire logic          aclk,
  // write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_idx,
  input  wire logic [31:0]   wr_data,
  // read port
  input  wire logic [AW-1:0] rd_idx,
  output logic      [31:0]   rd_data
);
  logic [31:0] mem_reg [NPAD];  // shadow copy of written words; bus readback uses the live fields

  // write side
  always_ff @(posedge aclk) begin
    if (wr_en) begin
      mem_reg[wr_idx] <= wr_data;
    end
  end

  // read data comes from a register, one cycle after the index
  always_ff @(posedge aclk) begin
    rd_data <= mem_reg[rd_idx];
  end
endmodule
`default_nettype wire

// ### hdl/pfm_pad_mux.sv
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`default_nettype none
// Functional notes
// - select zero routes the primary function
// - selects one to fifteen route alternates
// - warm reset release loads default selects
// - power-on reset holds documented pad state
// - after release pad may drive clock
// - unrouted peripheral input gets deselected value
// - driver off puts output buffer hi-z
// - software enables one pull at a time, pullup or pulldown by direction bit
module pfm_pad_mux
  import pfm_pkg::*;
#(
  parameter int NPAD = 8,            // number of pads
  parameter int NIN  = 8,            // number of peripheral inputs
  parameter int AW   = 3,            // pad index width
  parameter int IW   = 3,            // peripheral input index width
  // per pad function source table: 16 function outputs per pad,
  // each pad function k drives from peripheral output pad*16+k
  parameter logic [NPAD*3-1:0] POR_STATE = '0,
  parameter logic [NPAD*4-1:0] DEF_SEL   = '0,
  parameter logic [NPAD*3-1:0] REL_STATE = {NPAD{3'(PFM_RST_OFF)}},
  parameter logic [NPAD-1:0]   HAS_PULL  = '1,
  // peripheral input index each pad/function feeds, NIN means none
  parameter logic [NPAD*16*4-1:0] IN_MAP = '1,
  parameter logic [NIN*2-1:0]  DESEL_VAL = '0
) (
  // clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // power-on reset held active low, warm reset output active low
  input  wire logic                por_n,
  input  wire logic                warm_reset_output_signal_n,
  // toggling clock offered to pads in drive-clock state
  input  wire logic                pad_clk_src,
  // axi4-lite write address
  input  wire logic [11:0]         s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // axi4-lite write response
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // axi4-lite read address
  input  wire logic [11:0]         s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  // axi4-lite read data
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // peripheral side: 16 function outputs and enables per pad
  input  wire logic [NPAD*16-1:0]  func_out,
  input  wire logic [NPAD*16-1:0]  func_oe,
  // peripheral inputs after muxing
  output logic      [NIN-1:0]      periph_in,
  // pad side
  input  wire logic [NPAD-1:0]     pad_i,
  output logic      [NPAD-1:0]     pad_o,
  output logic      [NPAD-1:0]     pad_oe,
  output logic      [NPAD-1:0]     pad_pu_en,
  output logic      [NPAD-1:0]     pad_pd_en
);
  // per pad fields
  logic [3:0]  sel_reg    [NPAD];   // function select
  logic [NPAD-1:0] pullen_reg;      // pull enable
  logic [NPAD-1:0] pullup_reg;      // pull direction, 1 = up
  logic [NPAD-1:0] drvoff_reg;      // driver off
  logic [NPAD-1:0] clkdrv_reg;      // pad drives the clock source
  pfm_phase_t  phase_reg;
  logic        warm_q_reg;          // last warm reset level

  // bus state
  logic        aw_hold_reg;
  logic        w_hold_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        rd_pend_reg;          // mem read in flight
  logic [11:0] araddr_reg;
  logic [31:0] mem_rd;
  logic        wr_go;
  logic        wr_hit;
  logic [AW-1:0] wr_pad;
  logic [31:0] merged;

  // pad index decode, shared by read and write
  function automatic logic [AW-1:0] pad_of(input logic [11:0] a);
    return a[AW+1:2];
  endfunction
  function automatic logic in_pads(input logic [11:0] a,
                                   input logic [11:0] b);
    return (a >= b) && (a < b + 12'(NPAD*4)) && (a[1:0] == 2'b00);
  endfunction

  // write issues once both address and data are held
  assign wr_go  = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  assign wr_hit = in_pads(awaddr_reg, PFM_PAD_BASE) && phase_reg == PFM_PH_RUN;
  assign wr_pad = pad_of(awaddr_reg);

  // byte-lane merge of the new word over the current fields
  always_comb begin
    merged = {13'h0000, drvoff_reg[wr_pad], pullup_reg[wr_pad],
              pullen_reg[wr_pad], 12'h000, sel_reg[wr_pad]};
    for (int b = 0; b < 4; b++) begin
      if (wstrb_reg[b]) begin
        merged[b*8 +: 8] = wdata_reg[b*8 +: 8];
      end
    end
  end

  // write channel capture, either order accepted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg   <= 1'b0;
      w_hold_reg    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      awaddr_reg    <= 12'h000;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
    end else begin
      s_axi_awready <= !aw_hold_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_hold_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
      end
    end
  end

  // write response; slverr for unmapped or writes during reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= PFM_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? PFM_RESP_OKAY : PFM_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // track warm reset edges and phase
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_reg  <= PFM_PH_POR;
      warm_q_reg <= 1'b0;
    end else begin
      warm_q_reg <= warm_reset_output_signal_n;
      case (phase_reg)
        PFM_PH_POR:  if (por_n) phase_reg <= PFM_PH_HOLD;
        PFM_PH_HOLD: begin
          // a new power-on reset wins over a pending warm release
          if (!por_n) begin
            phase_reg <= PFM_PH_POR;
          end else if (warm_reset_output_signal_n) begin
            phase_reg <= PFM_PH_RUN;
          end
        end
        PFM_PH_RUN: begin
          if (!por_n) begin
            phase_reg <= PFM_PH_POR;
          end else if (!warm_reset_output_signal_n) begin
            phase_reg <= PFM_PH_HOLD;
          end
        end
        default: phase_reg <= PFM_PH_POR;
      endcase
    end
  end

  // pad fields: defaults on warm release, software writes afterwards
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int p = 0; p < NPAD; p++) begin
        sel_reg[p] <= 4'h0;
      end
      pullen_reg <= '0;
      pullup_reg <= '0;
      drvoff_reg <= '1;
      clkdrv_reg <= '0;
    end else if (phase_reg == PFM_PH_HOLD && warm_reset_output_signal_n
                 && por_n) begin
      for (int p = 0; p < NPAD; p++) begin
        sel_reg[p] <= DEF_SEL[p*4 +: 4];
        case (pfm_rst_state_t'(REL_STATE[p*3 +: 3]))
          PFM_RST_PD, PFM_RST_PU: begin
            pullen_reg[p] <= HAS_PULL[p];
            pullup_reg[p] <= REL_STATE[p*3 +: 3] == 3'(PFM_RST_PU);
            drvoff_reg[p] <= 1'b1;
            clkdrv_reg[p] <= 1'b0;
          end
          PFM_RST_OFF: begin
            pullen_reg[p] <= 1'b0;
            pullup_reg[p] <= 1'b0;
            drvoff_reg[p] <= 1'b1;
            clkdrv_reg[p] <= 1'b0;
          end
          default: begin
            // drive 0/1 follows the function; codes 5+ drive the clock
            pullen_reg[p] <= 1'b0;
            pullup_reg[p] <= 1'b0;
            drvoff_reg[p] <= 1'b0;
            clkdrv_reg[p] <= REL_STATE[p*3 +: 3] > 3'(PFM_RST_PU);
          end
        endcase
      end
    end else if (wr_go && wr_hit) begin
      sel_reg[wr_pad]    <= merged[PFM_SEL_LSB +: PFM_SEL_W];
      // pulls only exist where the pad has resistors
      pullen_reg[wr_pad] <= merged[PFM_PULLEN_BIT]
                            && HAS_PULL[wr_pad];
      pullup_reg[wr_pad] <= merged[PFM_PULLUP_BIT];
      drvoff_reg[wr_pad] <= merged[PFM_DRVOFF_BIT];
      clkdrv_reg[wr_pad] <= 1'b0;
    end
  end

  // read channel: mem index first, data one cycle later
  pfm_cfg_mem #(.NPAD(NPAD), .AW(AW)) u_mem (
    .aclk    (aclk),
    .wr_en   (wr_go && wr_hit),
    .wr_idx  (wr_pad),
    .wr_data (merged),
    .rd_idx  (pad_of(s_axi_araddr)),
    .rd_data (mem_rd)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= PFM_RESP_OKAY;
      rd_pend_reg   <= 1'b0;
      araddr_reg    <= 12'h000;
    end else begin
      s_axi_arready <= !s_axi_arready && !rd_pend_reg && !s_axi_rvalid
                       && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        rd_pend_reg <= 1'b1;
        araddr_reg  <= s_axi_araddr;
      end
      if (rd_pend_reg) begin
        rd_pend_reg  <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= PFM_RESP_OKAY;
        // live fields shown, so defaults loaded at release read back
        if (in_pads(araddr_reg, PFM_PAD_BASE)) begin
          s_axi_rdata <= {13'h0000, drvoff_reg[pad_of(araddr_reg)],
                          pullup_reg[pad_of(araddr_reg)],
                          pullen_reg[pad_of(araddr_reg)], 12'h000,
                          sel_reg[pad_of(araddr_reg)]};
        end else if (araddr_reg == PFM_STAT_BASE) begin
          s_axi_rdata <= 32'(pad_i);
        end else if (araddr_reg == PFM_WARM_OFF) begin
          s_axi_rdata <= 32'(phase_reg);
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= PFM_RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // pad drivers
  always_ff @(posedge aclk) begin
    if (!aresetn || phase_reg == PFM_PH_POR) begin
      for (int p = 0; p < NPAD; p++) begin
        // power-on state per pad
        case (pfm_rst_state_t'(POR_STATE[p*3 +: 3]))
          PFM_RST_DRV0: begin pad_o[p] <= 1'b0; pad_oe[p] <= 1'b1; end
          PFM_RST_DRV1: begin pad_o[p] <= 1'b1; pad_oe[p] <= 1'b1; end
          default:      begin pad_o[p] <= 1'b0; pad_oe[p] <= 1'b0; end
        endcase
        pad_pd_en[p] <= POR_STATE[p*3 +: 3] == 3'(PFM_RST_PD);
        pad_pu_en[p] <= POR_STATE[p*3 +: 3] == 3'(PFM_RST_PU);
      end
    end else begin
      for (int p = 0; p < NPAD; p++) begin
        if (clkdrv_reg[p]) begin
          pad_o[p]  <= pad_clk_src;
          pad_oe[p] <= 1'b1;
        end else begin
          // select 0 is primary, 1..15 alternates, same table
          pad_o[p]  <= func_out[p*16 + int'(sel_reg[p])];
          pad_oe[p] <= func_oe[p*16 + int'(sel_reg[p])]
                       && !drvoff_reg[p];
        end
        pad_pu_en[p] <= pullen_reg[p] && pullup_reg[p] && !clkdrv_reg[p];
        pad_pd_en[p] <= pullen_reg[p] && !pullup_reg[p] && !clkdrv_reg[p];
      end
    end
  end

  // peripheral inputs: selected pad, else deselected value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      periph_in <= '0;
    end else begin
      for (int i = 0; i < NIN; i++) begin
        // deselected default
        case (DESEL_VAL[i*2 +: 2])
          PFM_DESEL_ONE: periph_in[i] <= 1'b1;
          PFM_DESEL_PIN: periph_in[i] <= 1'b0;
          default:      periph_in[i] <= 1'b0;
        endcase
        // a routed pad overrides; two routed pads is software error
        for (int p = 0; p < NPAD; p++) begin
          if (IN_MAP[(p*16 + int'(sel_reg[p]))*4 +: 4] == 4'(i)) begin
            periph_in[i] <= pad_i[p];
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### inc/pfm_pkg.sv
`default_nettype none
package pfm_pkg;
  // register map: pad configuration registers start at this byte address
  localparam logic [11:0] PFM_PAD_BASE    = 12'h0000;
  // single status word (reads all pad levels back), after the config block
  localparam logic [11:0] PFM_STAT_BASE   = 12'h0800;
  localparam logic [11:0] PFM_WARM_OFF    = 12'h0FFC;
  // field positions in a pad configuration register
  localparam int PFM_SEL_LSB   = 0;
  localparam int PFM_SEL_W     = 4;
  localparam int PFM_PULLEN_BIT = 16;
  localparam int PFM_PULLUP_BIT = 17;
  localparam int PFM_DRVOFF_BIT = 18;
  // power-on pad states
  typedef enum logic [2:0] {
    PFM_RST_DRV0, PFM_RST_DRV1, PFM_RST_OFF, PFM_RST_PD, PFM_RST_PU
  } pfm_rst_state_t;
  // deselected input value codes
  localparam logic [1:0] PFM_DESEL_ZERO = 2'h0;
  localparam logic [1:0] PFM_DESEL_ONE  = 2'h1;
  localparam logic [1:0] PFM_DESEL_PIN  = 2'h2;
  // axi answers
  localparam logic [1:0] PFM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PFM_RESP_SLVERR = 2'h2;
  // warm-reset phase of the block
  typedef enum logic [1:0] {
    PFM_PH_POR, PFM_PH_HOLD, PFM_PH_RUN
  } pfm_phase_t;
endpackage
`default_nettype wire
